/* cfg_gpio_mux.sv */
/*
 * Configuration store with APB access and GPIO control-function mux.
 * Assumes an APB master on clk, GPIO pins asynchronous to clk, and an
 * OTP macro with one-cycle read latency behind the loader.
 */
`timescale 1ns/100ps
`default_nettype none
module cfg_gpio_mux (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      otpStrap,
    input  wire logic [7:0]                otpData,
    output logic                           otpRdEn,
    output logic [7:0]                     otpAddr,
    input  wire logic [3:0]                gpioIn,
    output logic [3:0]                     gpioOut,
    output logic [3:0]                     gpioOe_n,
    output logic [3:0]                     lossOfSignal,
    output logic                           tieClearEn,
    output logic [7:0]                     synthStop,
    output logic [7:0]                     diffOutEn,
    output logic                           cfgReady,
    output logic                           irq
);

    // One-hot internal function driven by a control code
    function automatic logic [20:0] funcOneHot(input logic [6:0] code);
        logic [20:0] oh;
        oh = '0;
        if (code[6:4] == 3'h1 && code[1:0] == 2'h0) begin
            oh[cfg_pkg::FN_LOS + int'(code[3:2])] = 1'b1;
        end
        else if (code == cfg_pkg::CODE_TIE_CLR) begin
            oh[cfg_pkg::FN_TIE] = 1'b1;
        end
        else if (code[6:4] == 3'h4 && code[2]) begin
            oh[cfg_pkg::FN_STOP + int'({code[3], code[1:0]})] = 1'b1;
        end
        else if (code[6:4] == 3'h6 && !code[0]) begin
            oh[cfg_pkg::FN_DIFF + int'(code[3:1])] = 1'b1;
        end
        return oh;
    endfunction

    cfg_load_if ldBus ();

    logic [7:0]  cfgMem [0:cfg_pkg::CFG_NUM_REGS-1];
    logic [3:0]  gpioMeta;
    logic [3:0]  gpioSync;
    logic [20:0] pinFunc [0:cfg_pkg::CFG_NUM_GPIO-1];
    logic [20:0] funcAny;
    logic [3:0]  losPrev;
    logic        busyPrev;
    logic [4:0]  irqStatus;
    logic [4:0]  irqMask;
    logic [4:0]  irqSet;
    logic        ack;
    logic [7:0]  rdByte;
    logic        irqLine;

    wire logic [7:0] regIdx     = paddr[9:2];
    wire logic       inBank     = regIdx <= cfg_pkg::CFG_LAST_IDX;
    wire logic       isStatus   = regIdx == cfg_pkg::IDX_IRQ_STATUS;
    wire logic       isMask     = regIdx == cfg_pkg::IDX_IRQ_MASK;
    wire logic       aligned    = paddr[11:10] == 2'h0 &&
                                  paddr[1:0] == 2'h0;
    wire logic       mapped     = aligned && (inBank || isStatus ||
                                  isMask);
    wire logic       access     = psel && penable;
    wire logic       doWrite    = ack && pwrite && mapped;
    wire logic       loading    = ldBus.busy;
    wire logic [7:0] dpllCtl    = cfgMem[cfg_pkg::IDX_DPLL_CTRL];
    wire logic [7:0] stopReg    = cfgMem[cfg_pkg::IDX_SYNTH_STOP];
    wire logic [7:0] diffReg    = cfgMem[cfg_pkg::IDX_DIFF_EN];
    wire logic [4:0] irqPending = irqStatus & irqMask;

    cfg_otp_loader u_loader (
        .clk      (clk),
        .rst_n    (rst_n),
        .otpStrap (otpStrap),
        .otpData  (otpData),
        .otpRdEn  (otpRdEn),
        .otpAddr  (otpAddr),
        .ld       (ldBus.loader)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gpioMeta <= 4'h0;
            gpioSync <= 4'h0;
        end else begin
            gpioMeta <= gpioIn;
            gpioSync <= gpioMeta;
        end
    end

    genvar p;
    generate
        for (p = 0; p < cfg_pkg::CFG_NUM_GPIO; p++) begin : g_pin
            wire logic [7:0] pinCfg =
                cfgMem[cfg_pkg::IDX_GPIO0_CFG + 8'(p)];
            wire logic ctrlMode =
                !loading && !pinCfg[cfg_pkg::GPIO_STATUS_BIT];
            // Drive only once cfgReady is up, so no pin turns early
            wire logic irqMode =
                cfgReady && pinCfg == cfg_pkg::CODE_IRQ_OUT;
            assign pinFunc[p] = ctrlMode ?
                (funcOneHot(pinCfg[6:0]) & {21{gpioSync[p]}}) : '0;
            assign gpioOut[p]  = irqMode && irqLine;
            assign gpioOe_n[p] = !irqMode;
        end
    endgenerate

    // Several pins may carry one function; any of them asserts it
    always_comb begin
        funcAny = '0;
        for (int i = 0; i < cfg_pkg::CFG_NUM_GPIO; i++) begin
            funcAny = funcAny | pinFunc[i];
        end
    end

    // Function outputs registered; held idle until the load completes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lossOfSignal <= 4'h0;
            tieClearEn   <= 1'b0;
            synthStop    <= 8'h00;
            diffOutEn    <= 8'h00;
        end else if (loading) begin
            lossOfSignal <= 4'h0;
            tieClearEn   <= 1'b0;
            synthStop    <= 8'h00;
            diffOutEn    <= 8'h00;
        end else begin
            lossOfSignal <= funcAny[cfg_pkg::FN_LOS +: 4];
            tieClearEn   <= funcAny[cfg_pkg::FN_TIE] |
                            dpllCtl[cfg_pkg::DPLL_TIE_CLR_BIT];
            synthStop    <= funcAny[cfg_pkg::FN_STOP +: 8] | stopReg;
            diffOutEn    <= funcAny[cfg_pkg::FN_DIFF +: 8] | diffReg;
        end
    end

    always_ff @(posedge clk) begin
        if (ldBus.wrEn) begin
            cfgMem[ldBus.wrAddr] <= ldBus.wrData;
        end else if (doWrite && inBank) begin
            cfgMem[regIdx] <= pwdata[7:0];
        end
    end

    // Event sources for the sticky flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            losPrev  <= 4'h0;
            busyPrev <= 1'b1;
        end else begin
            losPrev  <= lossOfSignal;
            busyPrev <= loading;
        end
    end

    assign irqSet = {busyPrev && !loading, lossOfSignal & ~losPrev};

    // Set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus <= cfg_pkg::IRQ_RESET;
            irqMask   <= cfg_pkg::IRQ_RESET;
        end else begin
            if (doWrite && isStatus) begin
                irqStatus <= (irqStatus & ~pwdata[4:0]) | irqSet;
            end else begin
                irqStatus <= irqStatus | irqSet;
            end
            if (doWrite && isMask) begin
                irqMask <= pwdata[4:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqLine  <= 1'b0;
            cfgReady <= 1'b0;
        end else begin
            irqLine  <= |irqPending;
            cfgReady <= !loading;
        end
    end

    assign irq = irqLine;

    // Read mux; out-of-bank indices never touch the array
    always_comb begin
        rdByte = 8'h00;
        if (aligned && inBank) begin
            rdByte = cfgMem[regIdx];
        end else if (aligned && isStatus) begin
            rdByte = {3'h0, irqStatus};
        end else if (aligned && isMask) begin
            rdByte = {3'h0, irqMask};
        end
    end

    // One wait state; the bus stalls while the power-up load runs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack    <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            ack <= access && !ack && !loading;
            if (access && !ack && !loading && !pwrite) begin
                prdata <= {24'h000000, rdByte};
            end
        end
    end

    assign pready  = ack;
    assign pslverr = ack && !mapped;

endmodule
`default_nettype wire

/* cfg_gpio_mux_checker.sv */
/*
 * Concurrent checks on the config store and GPIO mux top ports.
 * Assumes one clock domain and the registered APB answer of the design.
 */
`timescale 1ns/100ps
`default_nettype none
module cfg_gpio_mux_checker (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pready,
    input  wire logic       pslverr,
    input  wire logic [3:0] gpioIn,
    input  wire logic [3:0] gpioOe_n,
    input  wire logic [3:0] lossOfSignal,
    input  wire logic       tieClearEn,
    input  wire logic [7:0] synthStop,
    input  wire logic [7:0] diffOutEn,
    input  wire logic       cfgReady,
    input  wire logic       otpRdEn,
    input  wire logic [7:0] otpAddr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_with_ack: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_ack_after_access: assert property (
        pready |-> $past(psel) && $past(penable))
        else $error("pready without an access phase");
    a_otp_addr_walk: assert property (
        otpRdEn && $past(otpRdEn) |-> otpAddr == $past(otpAddr) + 8'h01)
        else $error("OTP address did not step by one");
    a_otp_stops: assert property (cfgReady |-> !otpRdEn)
        else $error("OTP read after load finished");
    a_ready_stays: assert property (cfgReady |=> cfgReady)
        else $error("cfgReady fell without reset");
    a_idle_in_load: assert property (!cfgReady |->
        {lossOfSignal, tieClearEn, synthStop, diffOutEn} == 21'h0)
        else $error("function output active during load");
    a_drive_loaded: assert property (gpioOe_n != 4'hf |-> cfgReady)
        else $error("pin driven before load finished");
    a_loss_synced: assert property (
        $rose(lossOfSignal[0]) |-> $past(gpioIn, 3) != 4'h0)
        else $error("loss output rose without an earlier pin level");
endmodule

bind cfg_gpio_mux cfg_gpio_mux_checker i_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .gpioIn(gpioIn),
    .gpioOe_n(gpioOe_n), .lossOfSignal(lossOfSignal),
    .tieClearEn(tieClearEn), .synthStop(synthStop), .diffOutEn(diffOutEn),
    .cfgReady(cfgReady), .otpRdEn(otpRdEn), .otpAddr(otpAddr)
);
`default_nettype wire

/* cfg_gpio_mux_tb.sv */
/*
 * Self-checking bench for the config store and GPIO function mux.
 * Assumes an OTP model on the loader port and board drivers on the pins.
 */
`timescale 1ns/100ps
`default_nettype none
module cfg_gpio_mux_tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  otpData, otpAddr, synthStop, diffOutEn;
    logic        otpRdEn, tieClearEn, cfgReady, irq;
    logic [3:0]  pinDrv, pinLvl, gpioOut, gpioOe_n, lossOfSignal;
    logic        strap;
    int          fails, checks;

    // Codes walked by the function table, grouped by rule
    logic [7:0]  codes [27] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c,
        8'h20, 8'h44, 8'h45, 8'h46, 8'h47, 8'h4c, 8'h4d, 8'h4e, 8'h4f,
        8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6e, 8'h30,
        8'h61, 8'h7f, 8'h90, 8'h70};

    // Pin level: device drives where its enable is low, board elsewhere
    assign pinLvl = (gpioOe_n & pinDrv) | (~gpioOe_n & gpioOut);

    cfg_gpio_mux i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .otpStrap(strap), .otpData(otpData), .otpRdEn(otpRdEn),
        .otpAddr(otpAddr), .gpioIn(pinLvl), .gpioOut(gpioOut),
        .gpioOe_n(gpioOe_n), .lossOfSignal(lossOfSignal),
        .tieClearEn(tieClearEn), .synthStop(synthStop),
        .diffOutEn(diffOutEn), .cfgReady(cfgReady), .irq(irq));
    cfg_otp_model i_otp (.clk(clk), .otpRdEn(otpRdEn), .otpAddr(otpAddr),
        .otpData(otpData));

    always #2 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic [7:0] idx, input logic wr,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Waits as long as the slave stalls; the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(idx, 1'b1, d, r, e);
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] e,
                         input logic eErr);
        logic [31:0] r;
        logic        er;
        apb(idx, 1'b0, 8'h00, r, er);
        chk("prdata", e, r);
        chk("pslverr", {31'h0, eErr}, {31'h0, er});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [20:0] funcOf(input logic [7:0] c);
        logic [20:0] f;
        f = '0;
        if (c inside {8'h10, 8'h14, 8'h18, 8'h1c}) f[17 + c[3:2]] = 1'b1;
        if (c == 8'h20) f[16] = 1'b1;
        if (c inside {[8'h44:8'h47]}) f[8 + c[1:0]] = 1'b1;
        if (c inside {[8'h4c:8'h4f]}) f[12 + c[1:0]] = 1'b1;
        if (c inside {[8'h60:8'h6e]} && !c[0]) f[c[3:1]] = 1'b1;
        return f;
    endfunction

    function automatic logic [31:0] outs();
        return {11'h0, lossOfSignal, tieClearEn, synthStop, diffOutEn};
    endfunction

    // No limit of its own: the watchdog ends a load that never finishes
    task automatic waitLoad;
        while (cfgReady !== 1'b1) settle(1);
        settle(1);
    endtask

    task automatic afterLoad;
        waitLoad();
        chk("synthStop", 32'h42, {24'h0, synthStop});
        chk("diffOutEn", 32'h43, {24'h0, diffOutEn});
        chk("tieClearEn", 32'h1, {31'h0, tieClearEn});
        chk("irq", 32'h0, {31'h0, irq});
        rdChk(8'h05, 32'h36, 1'b0);
        rdChk(8'hfe, 32'h10, 1'b0);
    endtask

    task automatic bankAccess;
        rdChk(8'hfc, 32'h2d, 1'b0);
        wr(8'hfc, 8'ha5);
        rdChk(8'hfc, 32'ha5, 1'b0);
        wr(8'hfd, 8'h77);
        rdChk(8'hfd, 32'h0, 1'b1);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h00);
        settle(2);
        chk("funcs", 32'h0, outs());
    endtask

    // One code per pass, pins taken in turn, pin high for each code
    task automatic codeRun(input int lo, input int hi);
        int p;
        for (int i = lo; i <= hi; i++) begin
            p = i % 4;
            wr(p[7:0], codes[i]);
            @(posedge clk) pinDrv[p] <= 1'b1;
            settle(5);
            chk("funcs", {11'h0, funcOf(codes[i])}, outs());
            @(posedge clk) pinDrv[p] <= 1'b0;
            wr(p[7:0], 8'h00);
        end
    endtask

    task automatic funcTable;
        codeRun(0, 0);
        codeRun(1, 4);
        codeRun(5, 5);
        codeRun(6, 13);
        codeRun(14, 20);
        codeRun(21, 21);
        codeRun(22, 26);
    endtask

    task automatic orTest;
        wr(8'h11, 8'h01);
        wr(8'h12, 8'h80);
        wr(8'h00, 8'h45);
        wr(8'h01, 8'h60);
        wr(8'h02, 8'h20);
        @(posedge clk) pinDrv <= 4'h7;
        settle(5);
        chk("orHigh", 32'h10381, outs());
        @(posedge clk) pinDrv <= 4'h0;
        settle(5);
        chk("orLow", 32'h00180, outs());
        for (int i = 0; i < 3; i++) wr(i[7:0], 8'h00);
    endtask

    task automatic irqTest;
        wr(8'hfe, 8'h1f);
        rdChk(8'hfe, 32'h0, 1'b0);
        wr(8'hff, 8'h01);
        wr(8'h00, 8'h10);
        wr(8'h03, 8'h80);
        @(posedge clk) pinDrv[0] <= 1'b1;
        settle(6);
        chk("irq", 32'h1, {31'h0, irq});
        chk("pinOe", 32'h7, {28'h0, gpioOe_n});
        chk("pinLvl", 32'h1, {31'h0, pinLvl[3]});
        wr(8'hff, 8'h00);
        settle(2);
        chk("irqMasked", 32'h0, {31'h0, irq});
        @(posedge clk) pinDrv[0] <= 1'b0;
        wr(8'hff, 8'h01);
        wr(8'hfe, 8'h01);
        settle(2);
        chk("irqCleared", 32'h0, {31'h0, irq});
        rdChk(8'hfe, 32'h0, 1'b0);
    endtask

    // Second reset in mid-run with the strap low: defaults, not OTP
    task automatic reloadDefaults;
        @(posedge clk);
        strap <= 1'b0;
        rst_n <= 1'b0;
        settle(3);
        chk("oeInReset", 32'hf, {28'h0, gpioOe_n});
        chk("readyInReset", 32'h0, {31'h0, cfgReady});
        @(posedge clk) rst_n <= 1'b1;
        settle(2);
        chk("readyEarly", 32'h0, {31'h0, cfgReady});
        waitLoad();
        chk("funcs", 32'h0, outs());
        rdChk(8'h05, 32'h00, 1'b0);
        rdChk(8'hfe, 32'h10, 1'b0);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        strap = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pinDrv = 4'h0;
        fails = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        afterLoad();
        bankAccess();
        funcTable();
        orTest();
        irqTest();
        reloadDefaults();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule
`default_nettype wire

/* cfg_load_if.sv */
/*
 * Write path from the power-up loader into the configuration bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface cfg_load_if;
    logic       wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic       busy;

    modport loader (output wrEn, output wrAddr, output wrData,
                    output busy);
    modport store  (input wrEn, input wrAddr, input wrData, input busy);
endinterface
`default_nettype wire

/* cfg_otp_loader.sv */
/*
 * Power-up loader: walks the whole bank once after reset and writes
 * either the one-time-programmable contents or the built-in default.
 * Assumes the OTP macro returns data one clock after a read strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module cfg_otp_loader (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       otpStrap,
    input  wire logic [7:0] otpData,
    output logic            otpRdEn,
    output logic [7:0]      otpAddr,
    cfg_load_if.loader      ld
);
    typedef enum logic [1:0] {LD_WAIT, LD_READ, LD_DONE} cfg_ld_state_t;

    cfg_ld_state_t state;
    logic [1:0]    waitCnt;
    logic          strapMeta;
    logic          strapSync;
    logic          useOtp;
    logic          wrPend;
    logic [7:0]    wrAddrQ;
    logic          lastAddr;

    assign lastAddr  = (otpAddr == cfg_pkg::CFG_LAST_IDX);
    assign otpRdEn   = (state == LD_READ);
    assign ld.wrEn   = wrPend;
    assign ld.wrAddr = wrAddrQ;
    assign ld.wrData = useOtp ? otpData : cfg_pkg::CFG_DEFAULT;
    assign ld.busy   = (state != LD_DONE) || wrPend;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strapMeta <= 1'b0;
            strapSync <= 1'b0;
        end else begin
            strapMeta <= otpStrap;
            strapSync <= strapMeta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= LD_WAIT;
            waitCnt <= 2'h0;
            useOtp  <= 1'b0;
            otpAddr <= 8'h00;
        end else begin
            unique case (state)
                LD_WAIT: begin
                    waitCnt <= waitCnt + 2'h1;
                    if (waitCnt == cfg_pkg::LD_WAIT_CYCLES) begin
                        useOtp <= strapSync;
                        state  <= LD_READ;
                    end
                end
                LD_READ: begin
                    if (lastAddr) begin
                        state <= LD_DONE;
                    end else begin
                        otpAddr <= otpAddr + 8'h01;
                    end
                end
                LD_DONE: begin
                    state <= LD_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend  <= 1'b0;
            wrAddrQ <= 8'h00;
        end else begin
            wrPend  <= otpRdEn;
            wrAddrQ <= otpAddr;
        end
    end
endmodule
`default_nettype wire

/* cfg_otp_model.sv */
/*
 * Behavioural OTP macro seen by the power-up loader.
 * Assumes one-cycle read latency on clk; contents are addr + 8'h31.
 */
`timescale 1ns/100ps
`default_nettype none
module cfg_otp_model (
    input  wire logic       clk,
    input  wire logic       otpRdEn,
    input  wire logic [7:0] otpAddr,
    output logic [7:0]      otpData
);
    initial otpData = 8'h00;
    // custom contents returned
    // Outside a read the bus toggles so a late sample never looks valid
    always @(posedge clk) begin
        otpData <= otpRdEn ? otpAddr + 8'h31 : ~otpData;
    end
endmodule
`default_nettype wire

/* cfg_pkg.sv */
/*
 * Constants shared by the configuration store and GPIO function mux.
 * Assumes APB with 32-bit data; every register sits in one aligned word.
 */
`default_nettype none
package cfg_pkg;

    // Configuration bank geometry
    localparam int          CFG_NUM_REGS   = 253;
    localparam logic [7:0]  CFG_LAST_IDX   = 8'hfc;
    localparam logic [7:0]  CFG_DEFAULT    = 8'h00;
    localparam int          CFG_NUM_GPIO   = 4;

    // Word indices; byte address is four times the index
    localparam logic [7:0]  IDX_GPIO0_CFG  = 8'h00;
    localparam logic [7:0]  IDX_DPLL_CTRL  = 8'h10;
    localparam logic [7:0]  IDX_SYNTH_STOP = 8'h11;
    localparam logic [7:0]  IDX_DIFF_EN    = 8'h12;
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'hfe;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'hff;

    // Field positions
    localparam int          DPLL_TIE_CLR_BIT = 0;
    localparam int          GPIO_STATUS_BIT  = 7;

    // GPIO function codes
    localparam logic [7:0]  CODE_IRQ_OUT   = 8'h80;
    localparam logic [6:0]  CODE_TIE_CLR   = 7'h20;

    // Internal function vector layout
    localparam int          FN_LOS         = 0;
    localparam int          FN_TIE         = 4;
    localparam int          FN_STOP        = 5;
    localparam int          FN_DIFF        = 13;
    localparam int          FN_COUNT       = 21;

    // Interrupt status bits: loss-of-signal rise per reference, load done
    localparam int          IRQ_LOAD_BIT   = 4;
    localparam int          IRQ_WIDTH      = 5;
    localparam logic [4:0]  IRQ_RESET      = 5'h00;

    // Loader start-up wait, covers the strap synchroniser
    localparam logic [1:0]  LD_WAIT_CYCLES = 2'h3;

endpackage
`default_nettype wire
